// file: verilog/spi_width_pin_baud_control.sv
// Serial peripheral core: transfer width, pin routing, wait stop, baud.
// Assumes one AHB-Lite master, the SPI pins, and a wait mode level.
// Operation
// RULE1 - Width bit 0: shift 8 bits, low data byte only, high unused.
// RULE2 - Width bit 1: shift 16 bits using high and low bytes.
// RULE3 - Master: changing width, fault, pin, baud fields aborts to idle.
// RULE4 - Master: output enable change aborts only in single-wire mode.
// RULE5 - Fault enable set: master detects fault through slave select.
// RULE6 - Master with fault enable clear ignores slave select pin.
// RULE7 - Slave always uses slave select as an input.
// RULE8 - Single-wire: enable gates MOSI as master, MISO as slave.
// RULE9 - Normal pins: master MISO in, MOSI out; slave reversed.
// RULE10 - Master single-wire: MISO unused, MOSI is the data line.
// RULE11 - Slave single-wire: MOSI unused, MISO is the data line.
// RULE12 - Wait stop set halts serial clock generation in wait mode.
// RULE13 - Divisor is (prescale plus one) times two to (exponent plus one).
// RULE14 - Both config registers read and write anytime; reserved ignored.
// RULE15 - Bit rate is bus clock divided by the divisor.
// RULE16 - Master select bit picks mode; switching forces idle.
// RULE17 - Exponent in baud bits 2 to 0; bits 7 and 3 read zero.
// RULE18 - Abort stops clock idle, clears count, drops partial word.
`timescale 1ns/100ps
`default_nettype none
module spi_width_pin_baud_control (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Serial pins
   input wire spi_cfg_pkg::spi_pin_in_t pins_in,
   output spi_cfg_pkg::spi_pin_out_t pins_out,
   // System
   input wire logic wait_mode,
   output logic irq
);
   spi_cfg_pkg::state_t st;
   spi_cfg_pkg::state_t n;
   logic wr;
   logic abort;
   logic in_bit;
   logic last;
   logic fault;

   // Half serial period in bus clocks
   function automatic logic [10:0] half_period(input logic [2:0] pp,
                                               input logic [2:0] rr);
      half_period = 11'({1'b0, pp} + 4'h1) << rr; // RULE13 RULE15
   endfunction

   // Register read mux
   function automatic logic [31:0] rd_mux(input spi_cfg_pkg::state_t s,
                                          input logic [2:0] idx);
      rd_mux = 32'h0;
      unique case (idx)
         spi_cfg_pkg::IDX_MODE: rd_mux[spi_cfg_pkg::MODE_MASTER_BIT] = s.master;
         spi_cfg_pkg::IDX_WPW: begin
            rd_mux[spi_cfg_pkg::WPW_WIDTH_BIT] = s.width;
            rd_mux[spi_cfg_pkg::WPW_MODE_FAULT_ENABLE_BIT] = s.mode_fault_enable;
            rd_mux[spi_cfg_pkg::WPW_SINGLE_WIRE_OUTPUT_ENABLE_BIT] = s.single_wire_output_enable;
            rd_mux[spi_cfg_pkg::WPW_SWAI_BIT] = s.swai;
            rd_mux[spi_cfg_pkg::WPW_BIDIRECTIONAL_PIN_SELECT_BIT] = s.bidirectional_pin_select;
         end
         spi_cfg_pkg::IDX_BAUD: begin
            rd_mux[spi_cfg_pkg::BAUD_SPPR_LSB +: 3] = s.sppr;
            rd_mux[spi_cfg_pkg::BAUD_SPR_LSB +: 3] = s.baud_exponent_field; // RULE17
         end
         spi_cfg_pkg::IDX_DHI: rd_mux[7:0] = s.width ? s.rx[15:8] : 8'h00; // RULE1
         spi_cfg_pkg::IDX_DLO: rd_mux[7:0] = s.rx[7:0];
         spi_cfg_pkg::IDX_ISTAT: rd_mux[2:0] = s.status;
         spi_cfg_pkg::IDX_IMASK: rd_mux[2:0] = s.mask;
         default: rd_mux = 32'h0;
      endcase
   endfunction

   // Reset image built from the documented reset values
   function automatic spi_cfg_pkg::state_t reset_state();
      reset_state = '0;
      reset_state.master = spi_cfg_pkg::MODE_RESET[spi_cfg_pkg::MODE_MASTER_BIT];
      reset_state.width = spi_cfg_pkg::WPW_RESET[spi_cfg_pkg::WPW_WIDTH_BIT];
      reset_state.mode_fault_enable = spi_cfg_pkg::WPW_RESET[spi_cfg_pkg::WPW_MODE_FAULT_ENABLE_BIT];
      reset_state.single_wire_output_enable = spi_cfg_pkg::WPW_RESET[spi_cfg_pkg::WPW_SINGLE_WIRE_OUTPUT_ENABLE_BIT];
      reset_state.swai = spi_cfg_pkg::WPW_RESET[spi_cfg_pkg::WPW_SWAI_BIT];
      reset_state.bidirectional_pin_select = spi_cfg_pkg::WPW_RESET[spi_cfg_pkg::WPW_BIDIRECTIONAL_PIN_SELECT_BIT];
      reset_state.sppr = spi_cfg_pkg::BAUD_RESET[spi_cfg_pkg::BAUD_SPPR_LSB +: 3];
      reset_state.baud_exponent_field = spi_cfg_pkg::BAUD_RESET[spi_cfg_pkg::BAUD_SPR_LSB +: 3];
      reset_state.mask = spi_cfg_pkg::IMASK_RESET;
      // Synchroniser stages start at the pin idle levels, so no false select follows reset
      reset_state.s1.ss_n = 1'b1;
      reset_state.s2.ss_n = 1'b1;
      reset_state.s3.ss_n = 1'b1;
      reset_state.filt.ss_n = 1'b1;
      reset_state.xfer = spi_cfg_pkg::XFER_IDLE;
   endfunction

   // Whole next-state computation
   always_comb begin
      n = st;
      wr = st.dp_valid && st.dp_write;
      abort = 1'b0;
      fault = 1'b0;
      // Three-stage input sync; a change counts when stages two and three agree
      n.s1 = pins_in;
      n.s2 = st.s1;
      n.s3 = st.s2;
      for (int i = 0; i < 4; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            n.filt[i] = st.s3[i];
         end
      end
      // Register writes; reserved bits are dropped
      if (wr) begin
         unique case (st.dp_idx)
            spi_cfg_pkg::IDX_MODE: begin
               n.master = hwdata[spi_cfg_pkg::MODE_MASTER_BIT];
               abort = n.master != st.master; // RULE16
            end
            spi_cfg_pkg::IDX_WPW: begin
               n.width = hwdata[spi_cfg_pkg::WPW_WIDTH_BIT]; // RULE14
               n.mode_fault_enable = hwdata[spi_cfg_pkg::WPW_MODE_FAULT_ENABLE_BIT];
               n.single_wire_output_enable = hwdata[spi_cfg_pkg::WPW_SINGLE_WIRE_OUTPUT_ENABLE_BIT];
               n.swai = hwdata[spi_cfg_pkg::WPW_SWAI_BIT];
               n.bidirectional_pin_select = hwdata[spi_cfg_pkg::WPW_BIDIRECTIONAL_PIN_SELECT_BIT];
               abort = st.master && (n.width != st.width || n.mode_fault_enable != st.mode_fault_enable
                       || n.bidirectional_pin_select != st.bidirectional_pin_select); // RULE3
               if (st.master && st.bidirectional_pin_select && n.single_wire_output_enable != st.single_wire_output_enable) begin
                  abort = 1'b1; // RULE4
               end
            end
            spi_cfg_pkg::IDX_BAUD: begin
               n.sppr = hwdata[spi_cfg_pkg::BAUD_SPPR_LSB +: 3];
               n.baud_exponent_field = hwdata[spi_cfg_pkg::BAUD_SPR_LSB +: 3]; // RULE17
               abort = st.master && (n.sppr != st.sppr || n.baud_exponent_field != st.baud_exponent_field); // RULE3
            end
            spi_cfg_pkg::IDX_DHI: n.tx[15:8] = hwdata[7:0]; // RULE2
            spi_cfg_pkg::IDX_DLO: n.tx[7:0] = hwdata[7:0];
            spi_cfg_pkg::IDX_IMASK: n.mask = hwdata[2:0];
            default: n.tx = n.tx;
         endcase
      end
      // Mode fault: master with fault enable sees slave select low
      if (st.master && st.mode_fault_enable && !st.filt.ss_n) begin // RULE5 RULE6
         fault = 1'b1;
         n.master = 1'b0;
      end
      // Data line per pin mode: single-wire uses MOSI as master, MISO as slave
      if (st.master) begin
         in_bit = st.bidirectional_pin_select ? st.filt.mosi : st.filt.miso; // RULE9 RULE10
      end else begin
         in_bit = st.bidirectional_pin_select ? st.filt.miso : st.filt.mosi; // RULE11
      end
      last = st.cnt == (st.width ? 5'd16 : 5'd8); // RULE1 RULE2
      // Transfer engine, mode 0, MSB first
      if (abort || fault) begin
         n.xfer = spi_cfg_pkg::XFER_IDLE; // RULE18
         n.sck = 1'b0;
         n.cnt = 5'd0;
         n.div = 11'd0;
         n.sh = 16'h0;
      end else if (st.master) begin
         if (st.xfer == spi_cfg_pkg::XFER_IDLE) begin
            if (wr && st.dp_idx == spi_cfg_pkg::IDX_DLO) begin
               n.xfer = spi_cfg_pkg::XFER_RUN;
               n.sh = n.tx;
               n.cnt = 5'd0;
               n.div = 11'd0;
               n.sck = 1'b0;
            end
         end else if (!(wait_mode && st.swai)) begin // RULE12
            if (st.div == half_period(st.sppr, st.baud_exponent_field) - 11'd1) begin
               n.div = 11'd0;
               n.sck = !st.sck;
               if (!st.sck) begin
                  n.smp = in_bit;
                  n.cnt = st.cnt + 5'd1;
               end else begin
                  n.sh = {st.sh[14:0], st.smp};
                  if (last) begin
                     n.xfer = spi_cfg_pkg::XFER_IDLE;
                     n.rx = st.width ? n.sh : {8'h00, n.sh[7:0]};
                     fault = 1'b0;
                  end
               end
            end else begin
               n.div = st.div + 11'd1; // RULE15
            end
         end
      end else begin
         // Slave follows the synchronised clock while selected
         n.sck = 1'b0;
         if (st.filt.ss_n) begin // RULE7
            n.cnt = 5'd0;
            n.sh = st.tx;
            n.xfer = spi_cfg_pkg::XFER_IDLE;
         end else if (n.filt.sck && !st.filt.sck) begin
            n.xfer = spi_cfg_pkg::XFER_RUN;
            n.smp = in_bit;
            n.cnt = st.cnt + 5'd1;
         end else if (!n.filt.sck && st.filt.sck) begin
            n.sh = {st.sh[14:0], st.smp};
            if (last) begin
               n.cnt = 5'd0;
               n.xfer = spi_cfg_pkg::XFER_IDLE;
               n.rx = st.width ? n.sh : {8'h00, n.sh[7:0]};
            end
         end
      end
      // Sticky events; a set in the clear cycle wins
      n.status = st.status;
      if (wr && st.dp_idx == spi_cfg_pkg::IDX_ISTAT) begin
         n.status = st.status & ~hwdata[2:0];
      end
      if (st.xfer == spi_cfg_pkg::XFER_RUN && n.xfer == spi_cfg_pkg::XFER_IDLE
          && !abort && !fault && (last || !st.master)) begin
         n.status[spi_cfg_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      if (fault) begin
         n.status[spi_cfg_pkg::IRQ_FAULT_BIT] = 1'b1;
      end
      if (abort && st.xfer == spi_cfg_pkg::XFER_RUN) begin
         n.status[spi_cfg_pkg::IRQ_ABORT_BIT] = 1'b1;
      end
      n.irq = |(n.status & n.mask);
      // AHB address phase capture; read data from post-write state
      n.dp_valid = hsel && hready && htrans[1];
      n.dp_write = hwrite;
      n.dp_idx = haddr[4:2];
      if (hsel && hready && htrans[1] && !hwrite) begin
         n.rdata = rd_mux(n, haddr[4:2]); // RULE14
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= reset_state();
      end else begin
         st <= n;
      end
   end

   // Bus answers: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign irq = st.irq;

   // Pin drivers and enables
   always_comb begin
      pins_out.sck = st.sck;
      pins_out.sck_oe_n = !st.master;
      pins_out.mosi = st.width ? st.sh[15] : st.sh[7];
      pins_out.miso = st.width ? st.sh[15] : st.sh[7];
      pins_out.mosi_oe_n = !(st.master && (!st.bidirectional_pin_select || st.single_wire_output_enable)); // RULE8 RULE9
      pins_out.miso_oe_n = !(!st.master && !st.filt.ss_n
                             && (!st.bidirectional_pin_select || st.single_wire_output_enable)); // RULE8 RULE11
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_cfg_abort;
      abort && st.xfer == spi_cfg_pkg::XFER_RUN;
   endsequence
   sequence s_idle_reset;
      st.xfer == spi_cfg_pkg::XFER_IDLE && st.cnt == 5'd0 && !st.sck;
   endsequence

   property p_width8;
      st.master && !st.width |-> st.cnt <= 5'd8;
   endproperty
   a_width8: assert property (p_width8) else $error("8-bit count overrun"); // RULE1

   property p_width16;
      n.xfer == spi_cfg_pkg::XFER_IDLE && st.xfer == spi_cfg_pkg::XFER_RUN
         && st.master && !abort && !fault |-> st.cnt == (st.width ? 5'd16 : 5'd8);
   endproperty
   a_width16: assert property (p_width16) else $error("Wrong word length"); // RULE2

   property p_abort;
      s_cfg_abort |=> s_idle_reset;
   endproperty
   a_abort: assert property (p_abort) else $error("Abort left engine busy"); // RULE3

   property p_oe_abort;
      wr && st.dp_idx == spi_cfg_pkg::IDX_WPW && st.master && !st.bidirectional_pin_select
         && !hwdata[spi_cfg_pkg::WPW_BIDIRECTIONAL_PIN_SELECT_BIT]
         && hwdata[spi_cfg_pkg::WPW_WIDTH_BIT] == st.width
         && hwdata[spi_cfg_pkg::WPW_MODE_FAULT_ENABLE_BIT] == st.mode_fault_enable |-> !abort;
   endproperty
   a_oe_abort: assert property (p_oe_abort) else $error("Spurious abort"); // RULE4

   property p_fault;
      st.master && st.mode_fault_enable && !st.filt.ss_n
         |=> !st.master && st.status[spi_cfg_pkg::IRQ_FAULT_BIT];
   endproperty
   a_fault: assert property (p_fault) else $error("Mode fault missed"); // RULE5

   property p_no_fault;
      st.master && !st.mode_fault_enable |=> st.master || $past(wr);
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("Select used"); // RULE6

   property p_bidi_master;
      st.master && st.bidirectional_pin_select && !st.single_wire_output_enable |-> pins_out.mosi_oe_n && pins_out.miso_oe_n;
   endproperty
   a_bidi_master: assert property (p_bidi_master) else $error("Master drove"); // RULE8

   property p_normal_master;
      st.master && !st.bidirectional_pin_select |-> !pins_out.mosi_oe_n && pins_out.miso_oe_n;
   endproperty
   a_normal_master: assert property (p_normal_master) else $error("Bad route"); // RULE9

   property p_wait_stop;
      st.master && st.swai && wait_mode && !abort && !fault |=> $stable(st.sck);
   endproperty
   a_wait_stop: assert property (p_wait_stop) else $error("Clock in wait"); // RULE12

   property p_divider;
      st.master && st.xfer == spi_cfg_pkg::XFER_RUN && !$stable(st.sck)
         && $past(st.xfer) == spi_cfg_pkg::XFER_RUN
         |-> $past(st.div) == half_period(st.sppr, st.baud_exponent_field) - 11'd1;
   endproperty
   a_divider: assert property (p_divider) else $error("Bad half period"); // RULE13

   property p_mode_switch;
      wr && st.dp_idx == spi_cfg_pkg::IDX_MODE
         && hwdata[spi_cfg_pkg::MODE_MASTER_BIT] != st.master
         |=> st.xfer == spi_cfg_pkg::XFER_IDLE;
   endproperty
   a_mode_switch: assert property (p_mode_switch) else $error("Switch not idle"); // RULE16
endmodule
`default_nettype wire

// file: verilog/spi_cfg_pkg.sv
// Constants and carrier types for the serial width, pin and baud block.
// Assumes a 32-bit AHB-Lite bus; registers sit at word index times four.
`default_nettype none
package spi_cfg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_MODE = 3'h0;
   localparam logic [2:0] IDX_WPW = 3'h1;
   localparam logic [2:0] IDX_BAUD = 3'h2;
   localparam logic [2:0] IDX_DHI = 3'h4;
   localparam logic [2:0] IDX_DLO = 3'h5;
   localparam logic [2:0] IDX_ISTAT = 3'h6;
   localparam logic [2:0] IDX_IMASK = 3'h7;
   // Field positions
   localparam int MODE_MASTER_BIT = 4;
   localparam int WPW_WIDTH_BIT = 6;
   localparam int WPW_MODE_FAULT_ENABLE_BIT = 4;
   localparam int WPW_SINGLE_WIRE_OUTPUT_ENABLE_BIT = 3;
   localparam int WPW_SWAI_BIT = 1;
   localparam int WPW_BIDIRECTIONAL_PIN_SELECT_BIT = 0;
   localparam int BAUD_SPPR_LSB = 4;
   localparam int BAUD_SPR_LSB = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam int IRQ_ABORT_BIT = 2;
   // Reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] WPW_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [2:0] IMASK_RESET = 3'h0;
   // Serial pins seen by the block
   typedef struct packed {
      logic sck;
      logic ss_n;
      logic mosi;
      logic miso;
   } spi_pin_in_t;
   // Serial pin drivers; enables are active low
   typedef struct packed {
      logic sck;
      logic sck_oe_n;
      logic mosi;
      logic mosi_oe_n;
      logic miso;
      logic miso_oe_n;
   } spi_pin_out_t;
   typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;
   // Whole state of the block
   typedef struct packed {
      logic master;
      logic width;
      logic mode_fault_enable;
      logic single_wire_output_enable;
      logic swai;
      logic bidirectional_pin_select;
      logic [2:0] sppr;
      logic [2:0] baud_exponent_field;
      logic [15:0] tx;
      logic [15:0] rx;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
      xfer_state_t xfer;
      logic [15:0] sh;
      logic smp;
      logic [4:0] cnt;
      logic [10:0] div;
      logic sck;
      spi_pin_in_t s1;
      spi_pin_in_t s2;
      spi_pin_in_t s3;
      spi_pin_in_t filt;
      logic dp_valid;
      logic dp_write;
      logic [2:0] dp_idx;
      logic [31:0] rdata;
   } state_t;
endpackage
`default_nettype wire

// file: tb/spi_far_model.sv
// Far-side serial device answering a master in mode 0, MSB first.
// Assumes the bench loads the reply word while the link is idle.
`timescale 1ns/100ps
`default_nettype none
module spi_far_model (
   // Control
   input wire logic hclk,
   input wire logic load,
   input wire logic drive,
   input wire logic wide,
   input wire logic [15:0] word,
   // Serial line
   input wire logic sck,
   output logic line
);
   logic [15:0] sr;
   logic junk = 1'b0;
   // Reply moves on after each falling clock edge
   always @(negedge sck or posedge load) begin
      if (load) begin
         sr <= word;
      end else begin
         sr <= sr << 1;
      end
   end
   // Changing pattern so a released line never looks settled
   always @(posedge hclk) begin
      junk <= ~junk;
   end
   assign line = drive ? (wide ? sr[15] : sr[7]) : junk;
endmodule
`default_nettype wire

// file: tb/spi_width_pin_baud_control_tb.sv
// Bench for the serial width, pin and baud block: bus tasks and scenarios.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module spi_width_pin_baud_control_tb;
   logic hclk, hresetn, hsel, hwrite, wait_mode, irq, hreadyout, hresp;
   logic ss_n, load, drive, wide, far_line, ps;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [15:0] txw, rxw, rp, seen;
   spi_cfg_pkg::spi_pin_in_t pin_in;
   spi_cfg_pkg::spi_pin_out_t pin_out;
   int errors, total_checks, cycles, n, dv, t, last, bits;
   int seed = 15058;
   int regs[8] = '{0, 0, 0, 0, 0, 0, 0, 0};
   int msk[8] = '{'h10, 'h5b, 'h77, 0, 0, 0, 0, 7};
   int bd[6][2] = '{'{0, 0}, '{1, 1}, '{0, 2}, '{2, 1}, '{7, 0}, '{4, 2}};
   int rt[6][5] = '{'{1, 0, 1, 0, 1}, '{1, 1, 1, 1, 1}, '{1, 9, 1, 0, 1},
      '{0, 0, 0, 1, 0}, '{0, 1, 0, 1, 1}, '{0, 9, 0, 1, 0}};
   int ab[8][4] = '{'{0, 1, 'h40, 1}, '{0, 1, 'h10, 1}, '{0, 1, 'h01, 1},
      '{0, 2, 'h67, 1}, '{0, 2, 'h76, 1}, '{0, 1, 'h08, 0}, '{1, 1, 'h09, 1},
      '{0, 0, 'h00, 1}};

   spi_width_pin_baud_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pins_in(pin_in), .pins_out(pin_out), .wait_mode(wait_mode), .irq(irq));
   spi_far_model far (.hclk(hclk), .load(load), .drive(drive), .wide(wide), .word(rp),
      .sck(pin_out.sck), .line(far_line));

   // Shared data lines resolve to whoever drives them
   always_comb begin
      pin_in.sck = 1'b0;
      pin_in.ss_n = ss_n;
      pin_in.mosi = pin_out.mosi_oe_n ? far_line : pin_out.mosi;
      pin_in.miso = pin_out.miso_oe_n ? far_line : pin_out.miso;
   end

   // Clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task conclude;
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One single AHB transfer; read data is taken at the data phase's edge
   task xfer_bus(input int idx, input logic wr_en, input logic [31:0] d);
      haddr <= 32'(idx * 4);
      htrans <= 2'h2;
      hwrite <= wr_en;
      hsel <= 1'b1;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
      if (wr_en && idx inside {0, 1, 2, 3, 7}) regs[idx] = d & msk[idx];
   endtask

   task wr(input int idx, input logic [31:0] d);
      xfer_bus(idx, 1'b1, d);
   endtask

   task rd(input int idx);
      xfer_bus(idx, 1'b0, 32'h0);
   endtask

   task rc(input int idx, input string nm);
      rd(idx);
      chk(nm, regs[idx], r);
      chk("hresp", 0, hresp);
   endtask

   // Hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         conclude();
      end
   end

   initial begin
      {hsel, hwrite, wait_mode, load, drive, wide} = '0;
      {htrans, haddr, hwdata, rp, cycles} = '0;
      ss_n = 1'b1;
      hresetn = 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset state
      rc(0, "mode_reset");
      rc(1, "wpw_reset");
      rc(2, "baud_reset");
      rc(7, "mask_reset");
      chk("irq_reset", 0, irq);
      // Random register traffic, reserved bits and the hole
      for (int i = 0; i < 6; i++) begin
         wr(1, $random(seed));
         wr(2, $random(seed));
         wr(3, $random(seed));
         wr(7, $random(seed));
         rc(1, "wpw_rw");
         rc(2, "baud_rw");
         rc(3, "hole_zero");
         rc(7, "mask_rw");
      end
      wr(7, 0);
      // Pin routing in each mode
      for (int i = 0; i < 6; i++) begin
         wr(0, rt[i][0] * 16);
         wr(1, rt[i][1]);
         ss_n <= rt[i][2][0];
         repeat (8) @(posedge hclk);
         chk("mosi_oe_n", rt[i][3], pin_out.mosi_oe_n);
         chk("miso_oe_n", rt[i][4], pin_out.miso_oe_n);
         chk("sck_oe_n", rt[i][0] == 0, pin_out.sck_oe_n);
      end
      ss_n <= 1'b1;
      // Master transfers over widths and divisors
      wr(0, 'h10);
      wr(1, 0);
      for (int i = 0; i < 6; i++) begin
         n = i % 2 ? 16 : 8;
         dv = (bd[i][0] + 1) * (2 ** (bd[i][1] + 1));
         txw = 16'($random(seed));
         rxw = 16'($random(seed));
         wr(1, n == 16 ? 'h40 : 'h00);
         wr(2, bd[i][0] * 16 + bd[i][1]);
         wr(6, 7);
         wr(4, txw[15:8]);
         rp <= rxw;
         load <= 1'b1;
         drive <= 1'b1;
         wide <= n == 16;
         wr(5, txw[7:0]);
         load <= 1'b0;
         bits = 0;
         t = 0;
         last = 0;
         ps = 1'b0;
         seen = 0;
         while (bits < n && t < 20000) begin
            @(posedge hclk);
            t++;
            if (pin_out.sck === 1'b1 && ps === 1'b0) begin
               if (bits > 0) chk("bit_period", dv, t - last);
               last = t;
               seen = {seen[14:0], pin_out.mosi};
               bits++;
            end
            ps = pin_out.sck;
         end
         chk("bits_sent", n == 16 ? txw : {8'h00, txw[7:0]}, seen);
         repeat (dv + 8) @(posedge hclk);
         drive <= 1'b0;
         rd(6);
         chk("done_flag", 1, r[0]);
         rd(4);
         if (dv >= 12 || n == 8) chk("rx_high", n == 16 ? rxw[15:8] : 8'h00, r[7:0]);
         rd(5);
         if (dv >= 12) chk("rx_low", rxw[7:0], r[7:0]);
      end
      // Config changes in mid-transfer
      for (int i = 0; i < 8; i++) begin
         wr(0, 'h10);
         wr(2, 'h77);
         wr(1, ab[i][0]);
         wr(6, 7);
         wr(5, 'h5a);
         repeat (20) @(posedge hclk);
         wr(ab[i][1], ab[i][2]);
         repeat (1100) @(posedge hclk);
         rd(6);
         chk("abort_flag", ab[i][3], r[2]);
         chk("no_done", 0, r[0]);
         if (ab[i][3] != 0) chk("sck_idle", 0, pin_out.sck);
      end
      // Abort status drives the line only while unmasked
      chk("irq_masked", 0, irq);
      wr(7, 4);
      repeat (2) @(posedge hclk);
      chk("irq_raised", 1, irq);
      wr(6, 4);
      repeat (2) @(posedge hclk);
      chk("irq_cleared", 0, irq);
      // Wait mode stalls the serial clock only with the stop bit set
      for (int s = 0; s < 2; s++) begin
         wr(0, 'h10);
         wr(2, 'h02);
         wr(1, s * 2);
         wr(6, 7);
         wait_mode <= 1'b1;
         wr(5, 'h3c);
         repeat (200) @(posedge hclk);
         rd(6);
         chk("wait_done", 1 - s, r[0]);
         wait_mode <= 1'b0;
         repeat (90) @(posedge hclk);
         rd(6);
         chk("wait_resume", 1, r[0]);
      end
      // Slave select low as master, fault detection off then on
      wr(1, 0);
      wr(6, 7);
      ss_n <= 1'b0;
      repeat (8) @(posedge hclk);
      rc(0, "master_kept");
      rd(6);
      chk("no_fault", 0, r[1]);
      wr(1, 'h10);
      repeat (8) @(posedge hclk);
      regs[0] = 0;
      rc(0, "master_dropped");
      rd(6);
      chk("fault_flag", 1, r[1]);
      conclude();
   end
endmodule
`default_nettype wire
